// *** src/aud_pkg.sv ***
// Constants, register map and carrier types of the audio output unit.
// Assumes a 25 MHz system clock and an APB master with 32-bit data.
//
// Functional notes
// - Resolution is 8, 10 or 12 bits, fixed at build time.
// - Build option picks pulse output or DAC output from same samples.
// - 8-bit: bit 7 is sign, bits 6..0 give the pulse length.
// - Low nibble register holds bits 3..0, 5..2 or 7..4 by resolution.
// - High nibble holds bits 7..4, 9..6 or 11..8; its top bit is sign.
// - 10-bit: lowest nibble bits 3..2 supply sample bits 1..0.
// - 12-bit: all lowest nibble bits supply sample bits 3..0.
// - Magnitude spans 0..511 in 10-bit and 0..2047 in 12-bit mode.
// - Output sample rate is the same fixed rate in every mode.
// - Each completed output cycle sets the sample request flag.
// - At cycle end the written sample moves into the active register.
// - Without a new write the previous sample is used again.
// - Control bit 0 enables output; when off both pins drive low.
// - Sleep clears the enable and floats both speaker pins.
// - Hardware never clears the request flag; software must.
// - Request rate 32768 Hz, doubled to 65536 Hz by build option.
// - Interrupt enable and flag set: take interrupt next clock, vector 8, clear interrupt enable.

`default_nettype none

package aud_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned REQ_RATE_HZ = 32768;
  localparam int unsigned REQ_RATE_FAST_HZ = 65536;
  // Cycles per output frame, rounded down so the rate is never slow
  localparam int unsigned FRAME_CYC = CLK_HZ / REQ_RATE_HZ;
  localparam int unsigned FRAME_CYC_FAST = CLK_HZ / REQ_RATE_FAST_HZ;

  // ************************************************************
  // Register indices (byte address is four times the index)
  // ************************************************************
  localparam logic [3:0] IDX_STATUS = 4'h0;
  localparam logic [3:0] IDX_LOWEST = 4'h8;
  localparam logic [3:0] IDX_CONTROL = 4'h9;
  localparam logic [3:0] IDX_LOW = 4'ha;
  localparam logic [3:0] IDX_HIGH = 4'hb;

  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int unsigned BIT_REQ_FLAG = 2;
  localparam int unsigned BIT_OUT_EN = 0;
  localparam int unsigned BIT_GIE = 1;
  localparam logic [3:0] NIBBLE_RST = 4'h0;
  localparam logic [11:0] IRQ_VECTOR = 12'h008;

  // ************************************************************
  // Carrier types
  // ************************************************************
  typedef struct packed {
    logic sign;
    logic [10:0] mag;
  } aud_sample_s;

  localparam aud_sample_s SAMPLE_RST = '{sign: 1'b0, mag: 11'h000};

endpackage : aud_pkg

`default_nettype wire

// *** src/aud_pulse_gen.sv ***
// Frame counter and sign-steered pulse generator of the audio unit.
// Assumes the active sample is held stable by the caller for a frame.

`default_nettype none

module aud_pulse_gen
#(
  parameter int unsigned RES_BITS = 8,
  parameter int unsigned FRAME = aud_pkg::FRAME_CYC
)
(
  // Clock and synchronised reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // Control and sample
  input wire logic run_in,
  input wire aud_pkg::aud_sample_s sample_in,
  // Frame timing and pin levels
  output logic frame_end_out,
  output logic pos_level_out,
  output logic neg_level_out
);
  import aud_pkg::*;

  localparam int unsigned CW = $clog2(FRAME);
  localparam logic [CW-1:0] LAST = CW'(FRAME - 1);

  logic [CW-1:0] cnt_q, cnt_d;
  logic pos_q, pos_d, neg_q, neg_d;
  logic [21:0] prod;
  logic [CW-1:0] thr;

  // The product is 22 bits, so frames must stay below 2048 clocks
  initial
  begin
    if (FRAME < 2 || FRAME > 2047 || RES_BITS < 8 || RES_BITS > 12)
      $error("pulse generator parameters out of range");
  end

  // Scale magnitude to the frame: one pulse step is FRAME/2^(RES-1) clocks
  assign prod = 22'(sample_in.mag) * 22'(FRAME);
  assign thr = CW'(prod >> (RES_BITS - 1));

  // Frame counter restarts whenever the output is off
  always_comb
  begin
    cnt_d = cnt_q;
    if (!run_in)
      cnt_d = '0;
    else if (cnt_q == LAST)
      cnt_d = '0;
    else
      cnt_d = cnt_q + CW'(1);
  end

  // Only one pin pulses, picked by the sign
  always_comb
  begin
    pos_d = run_in && !sample_in.sign && (cnt_q < thr);
    neg_d = run_in && sample_in.sign && (cnt_q < thr);
  end

  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cnt_q <= '0;
      pos_q <= 1'b0;
      neg_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      pos_q <= pos_d;
      neg_q <= neg_d;
    end
  end

  assign frame_end_out = run_in && (cnt_q == LAST);
  assign pos_level_out = pos_q;
  assign neg_level_out = neg_q;

  chk_one_pin: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    !(pos_q && neg_q))
    else $error("both speaker levels high");

endmodule : aud_pulse_gen

`default_nettype wire

// *** src/aud_pwm_dac.sv ***
// Top of the audio output unit: APB registers, sample double buffer,
// request flag and interrupt take, speaker pins and DAC level.
// Assumes halt and return-from-interrupt strobes from the CPU clock.
//
// Decided for this implementation: the APB register port.

`default_nettype none

module aud_pwm_dac
#(
  parameter int unsigned RES_BITS = 8,
  parameter bit DAC_MODE = 1'b0,
  parameter bit DOUBLE_RATE = 1'b0
)
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic resetn_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // CPU events
  input wire logic halt_in,
  input wire logic irq_return_in,
  output logic irq_take_out,
  output logic [11:0] irq_vector_out,
  // Speaker pins
  output logic speaker_out_pos_out,
  output logic speaker_out_pos_oe_out,
  output logic speaker_out_neg_out,
  output logic speaker_out_neg_oe_out,
  // DAC level
  output logic [11:0] dac_level_out
);
  import aud_pkg::*;

  // ************************************************************
  // Build options
  // ************************************************************
  localparam int unsigned FRAME = DOUBLE_RATE ? FRAME_CYC_FAST
                                              : FRAME_CYC;

  initial
  begin
    if (RES_BITS != 8 && RES_BITS != 10 && RES_BITS != 12)
      $error("resolution must be 8, 10 or 12");
  end

  // Sign-magnitude sample from the three nibbles, by resolution
  function automatic aud_sample_s assemble(input logic [3:0] dh,
                                           input logic [3:0] dl,
                                           input logic [3:0] dll);
    aud_sample_s s;
    s.sign = dh[3];
    if (RES_BITS == 12)
      s.mag = {dh[2:0], dl, dll};
    else if (RES_BITS == 10)
      s.mag = {2'b00, dh[2:0], dl, dll[3:2]};
    else
      s.mag = {4'h0, dh[2:0], dl};
    return s;
  endfunction : assemble

  // ************************************************************
  // Reset release
  // ************************************************************
  logic rst_meta_q, rst_n_q;

  // Assertion is asynchronous, release passes two flops
  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // ************************************************************
  // APB decode
  // ************************************************************
  logic pready_q, pready_d, slverr_q, slverr_d;
  logic [31:0] prdata_q, prdata_d;
  logic [3:0] idx;
  logic mapped, wr_fire;
  logic wr_status, wr_ctrl, wr_lowest, wr_low, wr_high;

  assign idx = paddr_in[5:2];
  assign mapped = (paddr_in[31:6] == 26'h000_0000) && (paddr_in[1:0] == 2'b00)
    && (idx == IDX_STATUS || idx == IDX_LOWEST || idx == IDX_CONTROL
        || idx == IDX_LOW || idx == IDX_HIGH);
  // Writes land only at the edge that completes the transfer
  assign wr_fire = psel_in && penable_in && pready_q && pwrite_in && mapped;
  assign wr_status = wr_fire && (idx == IDX_STATUS);
  assign wr_ctrl = wr_fire && (idx == IDX_CONTROL);
  assign wr_lowest = wr_fire && (idx == IDX_LOWEST);
  assign wr_low = wr_fire && (idx == IDX_LOW);
  assign wr_high = wr_fire && (idx == IDX_HIGH);

  // ************************************************************
  // Control, flag and sample state
  // ************************************************************
  logic en_q, en_d, gie_q, gie_d, flag_q, flag_d, take_q, take_d;
  logic [3:0] dll_q, dll_d, dl_q, dl_d, dh_q, dh_d;
  aud_sample_s active_q, active_d, staged;
  logic frame_end, start, pos_lvl, neg_lvl;

  assign staged = assemble(dh_q, dl_q, dll_q);
  assign start = en_d && !en_q;

  // One wait state so read data comes from a flop
  always_comb
  begin
    pready_d = psel_in && penable_in && !pready_q;
    slverr_d = pready_d && !mapped;
    prdata_d = prdata_q;
    if (pready_d)
    begin
      prdata_d = 32'h0000_0000;
      // A refused access must read 0 even if its index aliases a register
      if (mapped && !pwrite_in && idx == IDX_STATUS)
        prdata_d[BIT_REQ_FLAG] = flag_q;
      if (mapped && !pwrite_in && idx == IDX_CONTROL)
        prdata_d[1:0] = {gie_q, en_q};
    end
  end

  // Enable, interrupt enable, flag and interrupt take
  always_comb
  begin
    en_d = wr_ctrl ? pwdata_in[BIT_OUT_EN] : en_q;
    if (halt_in)
      en_d = 1'b0;
    gie_d = wr_ctrl ? pwdata_in[BIT_GIE] : gie_q;
    if (irq_return_in)
      gie_d = 1'b1;
    take_d = gie_q && flag_q;
    if (take_d)
      gie_d = 1'b0;
    // A frame end in the clearing cycle still sets the flag
    flag_d = (wr_status ? pwdata_in[BIT_REQ_FLAG] : flag_q)
             || frame_end;
  end

  // Written nibbles, copied into the active sample at frame end
  always_comb
  begin
    dll_d = wr_lowest ? pwdata_in[3:0] : dll_q;
    dl_d = wr_low ? pwdata_in[3:0] : dl_q;
    dh_d = wr_high ? pwdata_in[3:0] : dh_q;
    active_d = active_q;
    if (frame_end || start)
      active_d = staged;
  end

  always_ff @(posedge clock_in or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      pready_q <= 1'b0;
      slverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      en_q <= 1'b0;
      gie_q <= 1'b0;
      flag_q <= 1'b0;
      take_q <= 1'b0;
      dll_q <= NIBBLE_RST;
      dl_q <= NIBBLE_RST;
      dh_q <= NIBBLE_RST;
      active_q <= SAMPLE_RST;
    end
    else
    begin
      pready_q <= pready_d;
      slverr_q <= slverr_d;
      prdata_q <= prdata_d;
      en_q <= en_d;
      gie_q <= gie_d;
      flag_q <= flag_d;
      take_q <= take_d;
      dll_q <= dll_d;
      dl_q <= dl_d;
      dh_q <= dh_d;
      active_q <= active_d;
    end
  end

  // ************************************************************
  // Pulse engine and pins
  // ************************************************************
  aud_pulse_gen #(.RES_BITS(RES_BITS), .FRAME(FRAME)) u_pulse (
    .clock_in(clock_in),
    .rst_n_in(rst_n_q),
    .run_in(en_q),
    .sample_in(active_q),
    .frame_end_out(frame_end),
    .pos_level_out(pos_lvl),
    .neg_level_out(neg_lvl)
  );

  logic oe_q, oe_d;
  logic [11:0] dac_q, dac_d;

  // In DAC mode the pins stay low and the level port carries the sample
  always_comb
  begin
    oe_d = !halt_in;
    dac_d = 12'h000;
    if (DAC_MODE && en_q)
      dac_d = {active_q.sign, active_q.mag};
  end

  always_ff @(posedge clock_in or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      oe_q <= 1'b1;
      dac_q <= 12'h000;
    end
    else
    begin
      oe_q <= oe_d;
      dac_q <= dac_d;
    end
  end

  assign speaker_out_pos_out = !DAC_MODE && pos_lvl;
  assign speaker_out_neg_out = !DAC_MODE && neg_lvl;
  assign speaker_out_pos_oe_out = oe_q;
  assign speaker_out_neg_oe_out = oe_q;
  assign dac_level_out = dac_q;
  assign irq_take_out = take_q;
  assign irq_vector_out = IRQ_VECTOR;
  assign prdata_out = prdata_q;
  assign pready_out = pready_q;
  assign pslverr_out = slverr_q;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_n_q);

  chk_flag_on_frame: assert property (frame_end |=> flag_q)
    else $error("frame end did not set request flag");
  chk_flag_kept: assert property (flag_q && !wr_status |=> flag_q)
    else $error("request flag cleared without software write");
  chk_sample_load: assert property (frame_end
    |=> active_q == $past(staged))
    else $error("active sample not loaded at frame end");
  chk_sample_reuse: assert property (!frame_end && !start
    |=> $stable(active_q))
    else $error("active sample changed mid frame");
  chk_off_pins_low: assert property (!en_q && $past(!en_q)
    |-> !speaker_out_pos_out && !speaker_out_neg_out)
    else $error("speaker pin high while output disabled");
  chk_halt_float: assert property (halt_in
    |=> !en_q && !speaker_out_pos_oe_out && !speaker_out_neg_oe_out)
    else $error("halt did not disable and float pins");
  chk_irq_take: assert property (gie_q && flag_q
    |=> irq_take_out && !gie_q ##1 !irq_take_out)
    else $error("interrupt not taken for one cycle");
  chk_pin_sign: assert property (speaker_out_pos_out
    |-> !$past(active_q.sign) && !speaker_out_neg_out)
    else $error("positive pin pulsed for negative sample");
  chk_ctrl_write: assert property (wr_ctrl && !halt_in
    |=> en_q == $past(pwdata_in[0]))
    else $error("control write did not set output enable");

  // Each build drives only its own output: pins or level port
  chk_dac_pins_low: assert property (DAC_MODE
    |-> !speaker_out_pos_out && !speaker_out_neg_out)
    else $error("speaker pin pulsed in level build");
  chk_dac_level_idle: assert property (!DAC_MODE || !$past(en_q)
    |-> dac_level_out == 12'h000)
    else $error("level port set while unused");
  chk_ready_pulse: assert property (pready_out |=> !pready_out)
    else $error("ready held for more than one cycle");
  chk_bad_addr: assert property (psel_in && penable_in && !pready_out
    && !mapped |=> pready_out && pslverr_out && prdata_out == 32'h0000_0000)
    else $error("unmapped access not refused");
  chk_status_clear: assert property (wr_status
    && !pwdata_in[BIT_REQ_FLAG] && !frame_end |=> !flag_q)
    else $error("software clear of request flag lost");

  cov_frame: cover property (frame_end && flag_q);
  cov_take: cover property (irq_take_out);
  cov_neg: cover property (speaker_out_neg_out);
  cov_halt: cover property (en_q ##1 halt_in);

endmodule : aud_pwm_dac

`default_nettype wire

// *** tb/aud_spk_model.sv ***
// Speaker model between the two pulse pins of the audio unit.
// Assumes pin levels and enables that change just after a rising edge.
`default_nettype none

module aud_spk_model
(
  // Clock and window control
  input wire logic clock_in,
  input wire logic clear_in,
  // Pins of the unit
  input wire logic pos_in,
  input wire logic pos_oe_in,
  input wire logic neg_in,
  input wire logic neg_oe_in,
  // Driven-high cycles seen on each side
  output logic [15:0] pos_cnt_out,
  output logic [15:0] neg_cnt_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pos_last_q;
  logic neg_last_q;
  logic pos_wire;
  logic neg_wire;
  // A floated pin toggles every cycle, so a stale level never looks driven
  assign pos_wire = pos_oe_in ? pos_in : ~pos_last_q;
  assign neg_wire = neg_oe_in ? neg_in : ~neg_last_q;
  // Count only cycles where the pin is both driven and high
  always_ff @(posedge clock_in)
  begin
    pos_last_q <= pos_wire;
    neg_last_q <= neg_wire;
    if (clear_in)
    begin
      pos_cnt_out <= 16'h0000;
      neg_cnt_out <= 16'h0000;
    end
    else
    begin
      pos_cnt_out <= pos_cnt_out + 16'(pos_oe_in & pos_wire);
      neg_cnt_out <= neg_cnt_out + 16'(neg_oe_in & neg_wire);
    end
  end
endmodule : aud_spk_model

`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench of the audio unit: an 8-bit pulse instance, a 12-bit DAC
// instance and a 10-bit DAC instance share one APB master; a speaker model counts pulses.
`default_nettype none

`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin \
  n_errors++; $display("[ERR] %0t got %h exp %h", $time, got, exp); end end

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import aud_pkg::*;
  logic clock_in = 1'b0;
  logic resetn_in = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0000_0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic use_dac = 1'b0;
  logic use_ten = 1'b0;
  logic halt = 1'b0;
  logic irq_ret = 1'b0;
  logic clr = 1'b0;
  logic [31:0] prd_m, prd_d;
  logic rdy_m, rdy_d, err_m, err_d, irq_take, pos, pos_oe, neg, neg_oe;
  logic dpos, dneg;
  logic dtake, dpos_oe, dneg_oe, rdy_t, err_t, tpos, tneg;
  logic rdy_any, err_any;
  logic [31:0] prd_t, prd_any;
  logic [11:0] dvec, dac_lvl_m, tlvl;
  logic [11:0] vec, dac_lvl;
  logic [15:0] pcnt, ncnt;
  logic [7:0] smp [4] = '{8'h32, 8'hb2, 8'h7f, 8'h80};
  int n_errors = 0;
  int num_checks = 0;
  int n_irq = 0;
  int n_irq_d = 0;
  int pw;

  // Clock at 25 MHz
  initial
  begin
    forever #20 clock_in = ~clock_in;
  end

  aud_pwm_dac #(.RES_BITS(8), .DAC_MODE(1'b0), .DOUBLE_RATE(1'b0))
  aud_pwm_dac_inst (.clock_in(clock_in), .resetn_in(resetn_in),
    .psel_in(psel & ~use_dac & ~use_ten), .penable_in(penable),
    .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prd_m),
    .pready_out(rdy_m), .pslverr_out(err_m), .halt_in(halt),
    .irq_return_in(irq_ret), .irq_take_out(irq_take),
    .irq_vector_out(vec), .speaker_out_pos_out(pos),
    .speaker_out_pos_oe_out(pos_oe), .speaker_out_neg_out(neg),
    .speaker_out_neg_oe_out(neg_oe), .dac_level_out(dac_lvl_m));

  // Second build: DAC output at 12 bits, sharing sleep and return
  aud_pwm_dac #(.RES_BITS(12), .DAC_MODE(1'b1), .DOUBLE_RATE(1'b0))
  aud_pwm_dac_dac_inst (.clock_in(clock_in), .resetn_in(resetn_in),
    .psel_in(psel & use_dac), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prd_d),
    .pready_out(rdy_d), .pslverr_out(err_d), .halt_in(halt),
    .irq_return_in(irq_ret), .irq_take_out(dtake), .irq_vector_out(dvec),
    .speaker_out_pos_out(dpos), .speaker_out_pos_oe_out(dpos_oe),
    .speaker_out_neg_out(dneg), .speaker_out_neg_oe_out(dneg_oe),
    .dac_level_out(dac_lvl));

  // Third build: DAC output at 10 bits with the doubled request rate
  aud_pwm_dac #(.RES_BITS(10), .DAC_MODE(1'b1), .DOUBLE_RATE(1'b1))
  aud_pwm_dac_ten_inst (.clock_in(clock_in), .resetn_in(resetn_in),
    .psel_in(psel & use_ten), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prd_t),
    .pready_out(rdy_t), .pslverr_out(err_t), .halt_in(halt),
    .irq_return_in(irq_ret), .irq_take_out(), .irq_vector_out(),
    .speaker_out_pos_out(tpos), .speaker_out_pos_oe_out(),
    .speaker_out_neg_out(tneg), .speaker_out_neg_oe_out(),
    .dac_level_out(tlvl));

  // Only the selected build answers, so its reply is the one taken
  assign rdy_any = use_ten ? rdy_t : (use_dac ? rdy_d : rdy_m);
  assign prd_any = use_ten ? prd_t : (use_dac ? prd_d : prd_m);
  assign err_any = use_ten ? err_t : (use_dac ? err_d : err_m);

  aud_spk_model aud_spk_model_inst (.clock_in(clock_in), .clear_in(clr),
    .pos_in(pos), .pos_oe_in(pos_oe), .neg_in(neg), .neg_oe_in(neg_oe),
    .pos_cnt_out(pcnt), .neg_cnt_out(ncnt));

  // Count accepted interrupts
  always @(posedge clock_in)
  begin
    if (irq_take === 1'b1)
      n_irq <= n_irq + 1;
    if (dtake === 1'b1)
      n_irq_d <= n_irq_d + 1;
  end

  // ************************************************************
  // Bus tasks
  // ************************************************************
  task automatic apb(input logic wr, input logic [3:0] idx,
    input logic [31:0] wd, output logic [31:0] rd, output logic err);
    @(posedge clock_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {26'h000_0000, idx, 2'b00};
    pwdata <= wd;
    @(posedge clock_in);
    penable <= 1'b1;
    // Wait as long as the slave needs; only the watchdog ends a hang
    do
      @(posedge clock_in);
    while (rdy_any !== 1'b1);
    rd = prd_any;
    err = err_any;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wreg(input logic [3:0] idx, input logic [3:0] val);
    logic [31:0] rd;
    logic err;
    apb(1'b1, idx, {28'h000_0000, val}, rd, err);
  endtask : wreg

  task automatic rchk(input logic [3:0] idx, input logic [31:0] exp,
    input logic exp_err);
    logic [31:0] rd;
    logic err;
    apb(1'b0, idx, 32'h0000_0000, rd, err);
    `CHK(rd, exp)
    `CHK(err, exp_err)
  endtask : rchk

  // Pulse cycles over four whole frames, exact whatever the phase
  task automatic meas(input int ep, input int en);
    @(posedge clock_in);
    clr <= 1'b1;
    @(posedge clock_in);
    clr <= 1'b0;
    repeat (4 * FRAME_CYC) @(posedge clock_in);
    #1;
    `CHK(pcnt, 16'(ep))
    `CHK(ncnt, 16'(en))
  endtask : meas

  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : test_done

  // Watchdog well beyond the planned twenty-odd frames
  initial
  begin
    repeat (60000) @(posedge clock_in);
    n_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    test_done;
  end

  // ************************************************************
  // Tests
  // ************************************************************
  initial
  begin
    repeat (10) @(posedge clock_in);
    resetn_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    `CHK({pos_oe, neg_oe, pos, neg}, 4'b1100)
    rchk(IDX_STATUS, 32'h0000_0000, 1'b0);
    rchk(IDX_CONTROL, 32'h0000_0000, 1'b0);
    rchk(IDX_LOWEST, 32'h0000_0000, 1'b0);
    rchk(4'h5, 32'h0000_0000, 1'b1);
    $display("reset and map done");
    wreg(IDX_LOW, 4'h2);
    wreg(IDX_HIGH, 4'h3);
    wreg(IDX_CONTROL, 4'h1);
    for (int i = 0; i < 4; i++)
    begin
      wreg(IDX_LOW, smp[i][3:0]);
      wreg(IDX_HIGH, smp[i][7:4]);
      repeat (FRAME_CYC + 8) @(posedge clock_in);
      pw = 4 * ((int'(smp[i][6:0]) * FRAME_CYC) >> 7);
      meas(smp[i][7] ? 0 : pw, smp[i][7] ? pw : 0);
      `CHK(dac_lvl_m, 12'h000)
    end
    $display("pulse test done");
    rchk(IDX_STATUS, 32'h0000_0004, 1'b0);
    wreg(IDX_CONTROL, 4'h0);
    wreg(IDX_STATUS, 4'h0);
    rchk(IDX_STATUS, 32'h0000_0000, 1'b0);
    repeat (2 * FRAME_CYC) @(posedge clock_in);
    rchk(IDX_STATUS, 32'h0000_0000, 1'b0);
    wreg(IDX_CONTROL, 4'h1);
    repeat (FRAME_CYC + 8) @(posedge clock_in);
    rchk(IDX_STATUS, 32'h0000_0004, 1'b0);
    `CHK(n_irq, 0)
    wreg(IDX_CONTROL, 4'h3);
    repeat (8) @(posedge clock_in);
    `CHK(n_irq, 1)
    `CHK(vec, 12'h008)
    rchk(IDX_CONTROL, 32'h0000_0001, 1'b0);
    irq_ret <= 1'b1;
    @(posedge clock_in);
    irq_ret <= 1'b0;
    repeat (8) @(posedge clock_in);
    `CHK(n_irq, 2)
    $display("flag and interrupt test done");
    halt <= 1'b1;
    repeat (3) @(posedge clock_in);
    `CHK({pos_oe, neg_oe}, 2'b00)
    `CHK({dpos_oe, dneg_oe}, 2'b00)
    `CHK(dvec, 12'h008)
    rchk(IDX_CONTROL, 32'h0000_0000, 1'b0);
    halt <= 1'b0;
    repeat (3) @(posedge clock_in);
    `CHK({pos_oe, neg_oe, pos, neg}, 4'b1100)
    `CHK({dpos_oe, dneg_oe}, 2'b11)
    $display("sleep test done");
    use_dac <= 1'b1;
    wreg(IDX_LOWEST, 4'hf);
    wreg(IDX_LOW, 4'hf);
    wreg(IDX_HIGH, 4'h7);
    wreg(IDX_CONTROL, 4'h3);
    repeat (8) @(posedge clock_in);
    `CHK(dac_lvl, 12'h7ff)
    `CHK({dpos, dneg}, 2'b00)
    wreg(IDX_HIGH, 4'h8);
    wreg(IDX_LOW, 4'ha);
    wreg(IDX_LOWEST, 4'h5);
    repeat (FRAME_CYC + 8) @(posedge clock_in);
    `CHK(dac_lvl, 12'h8a5)
    `CHK(n_irq_d, 1)
    wreg(IDX_CONTROL, 4'h0);
    repeat (4) @(posedge clock_in);
    `CHK(dac_lvl, 12'h000)
    $display("dac test done");
    use_dac <= 1'b0;
    use_ten <= 1'b1;
    wreg(IDX_LOWEST, 4'hd);
    wreg(IDX_LOW, 4'h5);
    wreg(IDX_HIGH, 4'h3);
    wreg(IDX_CONTROL, 4'h1);
    // Flag must still be clear shortly before the short frame ends
    repeat (FRAME_CYC_FAST - 20) @(posedge clock_in);
    rchk(IDX_STATUS, 32'h0000_0000, 1'b0);
    repeat (30) @(posedge clock_in);
    rchk(IDX_STATUS, 32'h0000_0004, 1'b0);
    `CHK(tlvl, 12'h0d7)
    `CHK({tpos, tneg}, 2'b00)
    $display("ten-bit test done");
    test_done;
  end
endmodule : testbench

`default_nettype wire
